// *** rtl/csm_ctrl.sv ***
// capacitive-sense ramp, filter, pin-monitor and channel select control
`default_nettype none
// Function
// - ramp/filter bits 7:5 read zero, ignore writes
// - bits 4:3 choose ramp compensation range
// - bits 2:0 choose low-pass corner
// - bit 7 watches serial transmit output
// - bit 6 watches SPI output pins
// - bit 5 watches SMBus pins
// - bit 4 watches counter array outputs
// - bit 3 watches port latch writes
// - bit 2 watches comparator output
// - mode 00 retries bit cycle always
// - mode 01 retries at most twice
// - mode 10 four retries; 11 reserved
// - channel select by firmware or auto-scan
// - fourteen channels, codes 1110/1111 reserved
module csm_ctrl
   import csm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire csm_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic serial_tx_pin,
   input wire logic [2:0] spi_out_pins,
   input wire logic [1:0] smbus_pins,
   input wire logic [2:0] counter_array_pins,
   input wire logic port_latch_write,
   input wire logic comparator_out,
   input wire logic scan_load,
   input wire logic [3:0] scan_channel,
   input wire logic bit_done,
   output logic bit_retry,
   output logic [1:0] ramp_select,
   output logic [2:0] lowpass_select,
   output logic [3:0] sense_channel_select,
   output logic channel_valid,
   output logic [2:0] retry_count
);
   csm_ramp_filter_t sense_ramp_filter_cfg_reg; // ramp/filter register
   csm_ramp_filter_t sense_ramp_filter_cfg_next;
   csm_pin_monitor_t sense_pin_monitor_reg; // pin monitor register
   csm_pin_monitor_t sense_pin_monitor_next;
   logic [3:0] channel_reg; // mux channel select
   logic [3:0] channel_next;
   logic [7:0] rdata_reg; // registered read data
   logic [7:0] rdata_next;
   logic [CSM_NUM_WATCH-1:0] src_now; // current monitored levels
   logic [CSM_NUM_WATCH-1:0] src_reg; // previous monitored levels
   logic [CSM_NUM_WATCH-1:0] src_en; // enables per source
   logic [CSM_NUM_WATCH-1:0] src_evt; // change per source
   logic activity; // any enabled change

   // reduce each pin group to one change-detect level; the port latch slot is tied low
   assign src_now = {^serial_tx_pin, ^spi_out_pins, ^smbus_pins, ^counter_array_pins, 1'b0, comparator_out};
   assign src_en = {sense_pin_monitor_reg.serial_tx_watch_en,
                    sense_pin_monitor_reg.spi_out_watch_en,
                    sense_pin_monitor_reg.smbus_watch_en,
                    sense_pin_monitor_reg.counter_array_watch_en,
                    sense_pin_monitor_reg.port_latch_watch_en,
                    sense_pin_monitor_reg.comparator_watch_en};

   // per-source event detection
   genvar gi;
   generate
      for (gi = 0; gi < CSM_NUM_WATCH; gi++) begin : g_watch
         // source vector starts at the comparator bit, so the latch sits at its offset from there
         if (gi == CSM_POS_PORT_LATCH - CSM_POS_COMPARATOR) begin : g_latch
            // port latch: any write counts as an event
            assign src_evt[gi] = src_en[gi] && port_latch_write;
         end else begin : g_pin
            // pins: a change of the group level
            assign src_evt[gi] = src_en[gi] && (src_now[gi] != src_reg[gi]);
         end
      end
   endgenerate
   assign activity = |src_evt;

   // retry decision
   csm_retry_ctrl u_retry (
      .clk(clk),
      .rst_n(rst_n),
      .mode(sense_pin_monitor_reg.monitor_retry_mode),
      .activity(activity),
      .bit_done(bit_done),
      .bit_retry(bit_retry),
      .retry_count(retry_count)
   );

   // register writes, auto-scan load and read mux
   always_comb begin
      sense_ramp_filter_cfg_next = sense_ramp_filter_cfg_reg;
      sense_pin_monitor_next = sense_pin_monitor_reg;
      channel_next = channel_reg;
      rdata_next = rdata_reg;
      if (sfr_req.wr) begin
         case (sfr_req.addr)
            CSM_ADDR_RAMP_FILTER: begin
               sense_ramp_filter_cfg_next = csm_ramp_filter_t'(sfr_req.wdata & CSM_RAMP_FILTER_MASK);
            end
            CSM_ADDR_PIN_MONITOR: begin
               sense_pin_monitor_next = csm_pin_monitor_t'(sfr_req.wdata);
            end
            CSM_ADDR_CHANNEL_SEL: begin
               channel_next = sfr_req.wdata[3:0];
            end
            default: begin
               channel_next = channel_reg;
            end
         endcase
      end
      // auto-scan load takes priority over a firmware write
      if (scan_load) begin
         channel_next = scan_channel;
      end
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            CSM_ADDR_RAMP_FILTER: begin
               rdata_next = 8'(sense_ramp_filter_cfg_reg) & CSM_RAMP_FILTER_MASK;
            end
            CSM_ADDR_PIN_MONITOR: begin
               rdata_next = 8'(sense_pin_monitor_reg);
            end
            CSM_ADDR_CHANNEL_SEL: begin
               rdata_next = {4'h0, channel_reg};
            end
            default: begin
               rdata_next = 8'h0000;
            end
         endcase
      end
   end

   // register stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_ramp_filter_cfg_reg <= csm_ramp_filter_t'(CSM_RST_RAMP_FILTER);
         sense_pin_monitor_reg <= csm_pin_monitor_t'(CSM_RST_PIN_MONITOR);
         channel_reg <= CSM_RST_CHANNEL;
         rdata_reg <= 8'h0000;
         src_reg <= '0;
      end else begin
         sense_ramp_filter_cfg_reg <= sense_ramp_filter_cfg_next;
         sense_pin_monitor_reg <= sense_pin_monitor_next;
         channel_reg <= channel_next;
         rdata_reg <= rdata_next;
         src_reg <= src_now;
      end
   end

   // outputs to the converter core
   assign sfr_rdata = rdata_reg;
   assign sfr_hit = (sfr_req.addr == CSM_ADDR_RAMP_FILTER) || (sfr_req.addr == CSM_ADDR_PIN_MONITOR) ||
                    (sfr_req.addr == CSM_ADDR_CHANNEL_SEL);
   assign ramp_select = sense_ramp_filter_cfg_reg.ramp_select;
   assign lowpass_select = sense_ramp_filter_cfg_reg.lowpass_select;
   assign sense_channel_select = channel_reg;
   assign channel_valid = (channel_reg <= CSM_CHANNEL_LAST);
endmodule
`default_nettype wire

// *** include/csm_pkg.sv ***
// package for the capacitive-sense ramp, filter and pin-monitor block
`default_nettype none
package csm_pkg;
   // special function register addresses
   localparam logic [7:0] CSM_ADDR_PIN_MONITOR = 8'h00de;
   localparam logic [7:0] CSM_ADDR_RAMP_FILTER = 8'h00f3;
   localparam logic [7:0] CSM_ADDR_CHANNEL_SEL = 8'h00ab;
   // reset values
   localparam logic [7:0] CSM_RST_PIN_MONITOR = 8'h0000;
   localparam logic [7:0] CSM_RST_RAMP_FILTER = 8'h0000;
   localparam logic [3:0] CSM_RST_CHANNEL = 4'h0000;
   // field positions
   localparam int CSM_POS_SERIAL_TX = 7;
   localparam int CSM_POS_SPI_OUT = 6;
   localparam int CSM_POS_SMBUS = 5;
   localparam int CSM_POS_COUNTER = 4;
   localparam int CSM_POS_PORT_LATCH = 3;
   localparam int CSM_POS_COMPARATOR = 2;
   localparam int CSM_NUM_WATCH = 6;
   localparam logic [7:0] CSM_RAMP_FILTER_MASK = 8'h001f;
   localparam logic [7:0] CSM_CHANNEL_MASK = 8'h000f;
   // retry limits per mode
   localparam logic [2:0] CSM_RETRY_LIMIT_TWO = 3'h2;
   localparam logic [2:0] CSM_RETRY_LIMIT_FOUR = 3'h4;
   localparam logic [3:0] CSM_CHANNEL_LAST = 4'h000d;
   // monitor retry modes
   typedef enum logic [1:0] {
      CSM_MODE_ALWAYS = 2'b00,
      CSM_MODE_TWICE = 2'b01,
      CSM_MODE_FOUR = 2'b10,
      CSM_MODE_RSVD = 2'b11
   } csm_mode_t;
   // ramp/filter register layout
   typedef struct packed {
      logic [2:0] unused;
      logic [1:0] ramp_select;
      logic [2:0] lowpass_select;
   } csm_ramp_filter_t;
   // pin monitor register layout
   typedef struct packed {
      logic serial_tx_watch_en;
      logic spi_out_watch_en;
      logic smbus_watch_en;
      logic counter_array_watch_en;
      logic port_latch_watch_en;
      logic comparator_watch_en;
      csm_mode_t monitor_retry_mode;
   } csm_pin_monitor_t;
   // special function register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csm_sfr_req_t;
endpackage
`default_nettype wire

// *** rtl/csm_retry_ctrl.sv ***
// retry decision for converter bit cycles on monitored activity
`default_nettype none
module csm_retry_ctrl
   import csm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire csm_mode_t mode,
   input wire logic activity,
   input wire logic bit_done,
   output logic bit_retry,
   output logic [2:0] retry_count
);
   logic [2:0] count_reg; // retries on consecutive bit cycles
   logic [2:0] count_next;
   logic hit_reg; // activity seen in the current bit cycle
   logic hit_next;
   logic [2:0] limit; // allowed retries for mode
   logic allow; // retry still permitted

   // limit per mode; reserved code treated as always
   always_comb begin
      limit = CSM_RETRY_LIMIT_FOUR;
      allow = 1'b1;
      case (mode)
         CSM_MODE_ALWAYS: begin
            allow = 1'b1;
         end
         CSM_MODE_TWICE: begin
            limit = CSM_RETRY_LIMIT_TWO;
            allow = (count_reg < limit);
         end
         CSM_MODE_FOUR: begin
            limit = CSM_RETRY_LIMIT_FOUR;
            allow = (count_reg < limit);
         end
         default: begin
            allow = 1'b1;
         end
      endcase
   end

   // retry pulse at end of a bit cycle that saw activity
   assign bit_retry = bit_done && (hit_reg || activity) && allow;
   assign retry_count = count_reg;

   // next-state of counter and hit flag
   always_comb begin
      count_next = count_reg;
      hit_next = hit_reg || activity; // clear on bit_done wins over event
      if (bit_done) begin
         hit_next = 1'b0;
         if (bit_retry) begin
            if (count_reg != CSM_RETRY_LIMIT_FOUR) begin
               count_next = count_reg + 3'h1;
            end
         end else if (!(hit_reg || activity)) begin
            count_next = 3'h0;
         end
         // exhausted: cycle continues without retry, count held
      end
   end

   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 3'h0;
         hit_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         hit_reg <= hit_next;
      end
   end
endmodule
`default_nettype wire

// *** dv/csm_ctrl_checker.sv ***
// assertion checker for the sense control block
`default_nettype none
module csm_ctrl_checker
   import csm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire csm_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic scan_load,
   input wire logic [3:0] scan_channel,
   input wire logic bit_done,
   input wire logic bit_retry,
   input wire logic [1:0] ramp_select,
   input wire logic [2:0] lowpass_select,
   input wire logic [3:0] sense_channel_select,
   input wire logic channel_valid,
   input wire logic [2:0] retry_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] mode_reg; // copy of the retry mode field
   // follow firmware writes of the mode field
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mode_reg <= 2'h0;
      else if (sfr_req.wr && sfr_req.addr == CSM_ADDR_PIN_MONITOR) mode_reg <= sfr_req.wdata[1:0];
   end
   // config register write and read cycles
   sequence cfg_wr_s;
      sfr_req.wr && sfr_req.addr == CSM_ADDR_RAMP_FILTER;
   endsequence
   sequence cfg_rd_s;
      sfr_req.rd && sfr_req.addr == CSM_ADDR_RAMP_FILTER;
   endsequence
   unused_zero_a: assert property (cfg_rd_s |=> sfr_rdata[7:5] == 3'h0)
      else $error("config high bits not zero");
   ramp_load_a: assert property (cfg_wr_s |=> ramp_select == $past(sfr_req.wdata[4:3]))
      else $error("ramp field not loaded");
   filter_load_a: assert property (cfg_wr_s |=> lowpass_select == $past(sfr_req.wdata[2:0]))
      else $error("filter field not loaded");
   scan_load_a: assert property (scan_load |=> sense_channel_select == $past(scan_channel))
      else $error("scan channel not loaded");
   chan_valid_a: assert property (channel_valid == (sense_channel_select <= CSM_CHANNEL_LAST))
      else $error("channel valid wrong");
   twice_cap_a: assert property (bit_done && mode_reg == 2'h1 && retry_count >= 3'h2 |-> !bit_retry)
      else $error("retry beyond two");
   four_cap_a: assert property (bit_done && mode_reg == 2'h2 && retry_count >= 3'h4 |-> !bit_retry)
      else $error("retry beyond four");
   count_step_a: assert property (bit_done && bit_retry && mode_reg inside {2'h1, 2'h2}
      |=> retry_count == $past(retry_count) + 3'h1) else $error("retry count not stepped");
endmodule
bind csm_ctrl csm_ctrl_checker csm_ctrl_checker_inst (
   .clk(clk),
   .rst_n(rst_n),
   .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata),
   .scan_load(scan_load),
   .scan_channel(scan_channel),
   .bit_done(bit_done),
   .bit_retry(bit_retry),
   .ramp_select(ramp_select),
   .lowpass_select(lowpass_select),
   .sense_channel_select(sense_channel_select),
   .channel_valid(channel_valid),
   .retry_count(retry_count)
);
`default_nettype wire

// *** dv/csm_ctrl_test.sv ***
// self-checking bench for the sense control block
`default_nettype none
module csm_ctrl_test
   import csm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   csm_sfr_req_t req = '0; // register request
   logic [10:0] pins = '0; // watched inputs, bit 9 is the latch pulse
   logic scan_load = 1'b0;
   logic [3:0] scan_chan = 4'h0;
   logic bit_done = 1'b0;
   logic [7:0] rdata;
   logic hit, retry, cvalid;
   logic hit_seen = 1'b0; // address decode seen during the last access
   logic [1:0] ramp;
   logic [2:0] lp, rcount;
   logic [3:0] chan;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int pos[6] = '{0, 1, 4, 6, 9, 10}; // one pin per watched group
   logic [7:0] addrs[4] = '{CSM_ADDR_PIN_MONITOR, CSM_ADDR_RAMP_FILTER, CSM_ADDR_CHANNEL_SEL, 8'h00};
   always #5 clk = ~clk;
   csm_ctrl csm_ctrl_inst (.clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit),
      .serial_tx_pin(pins[0]), .spi_out_pins(pins[3:1]), .smbus_pins(pins[5:4]),
      .counter_array_pins(pins[8:6]), .port_latch_write(pins[9]), .comparator_out(pins[10]),
      .scan_load(scan_load), .scan_channel(scan_chan), .bit_done(bit_done), .bit_retry(retry),
      .ramp_select(ramp), .lowpass_select(lp), .sense_channel_select(chan), .channel_valid(cvalid),
      .retry_count(rcount));
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one register access, read data settled on return
   task automatic sfr(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
      @(posedge clk);
      hit_seen = hit;
      req <= '0;
      #1;
   endtask
   // change one watched pin, the latch strobe only pulses
   task automatic tog(input int k);
      @(posedge clk);
      pins[k] <= ~pins[k];
      @(posedge clk);
      if (k == 9) pins[9] <= 1'b0;
      @(posedge clk);
   endtask
   // end of a bit cycle with the expected retry answer
   task automatic bd(input logic exp);
      @(posedge clk);
      bit_done <= 1'b1;
      #1;
      chk(retry, exp);
      @(posedge clk);
      bit_done <= 1'b0;
      #1;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk(cvalid, 8'h01);
      foreach (addrs[i]) begin
         sfr(1'b0, addrs[i], 8'h00);
         chk(rdata, 8'h00);
         chk(hit_seen, 8'(i < 3));
      end
      sfr(1'b1, CSM_ADDR_RAMP_FILTER, 8'hff);
      sfr(1'b0, CSM_ADDR_RAMP_FILTER, 8'h00);
      chk(rdata, 8'h1f);
      for (int i = 0; i < 8; i++) begin
         sfr(1'b1, CSM_ADDR_RAMP_FILTER, 8'((i % 4) * 8 + i));
         chk({ramp, lp}, 8'((i % 4) * 8 + i));
      end
      sfr(1'b1, CSM_ADDR_RAMP_FILTER, 8'h09);
      chk({ramp, lp}, 8'h09);
      sfr(1'b1, CSM_ADDR_PIN_MONITOR, 8'hfe);
      sfr(1'b0, CSM_ADDR_PIN_MONITOR, 8'h00);
      chk(rdata, 8'hfe);
      sfr(1'b1, CSM_ADDR_CHANNEL_SEL, 8'h0d);
      chk({cvalid, chan}, 8'h1d);
      sfr(1'b1, CSM_ADDR_CHANNEL_SEL, 8'hfe);
      chk({cvalid, chan}, 8'h0e);
      @(posedge clk);
      scan_load <= 1'b1;
      scan_chan <= 4'h5;
      @(posedge clk);
      scan_load <= 1'b0;
      #1;
      chk(chan, 8'h05);
      // each watch enable, off then on, in twice mode
      for (int i = 0; i < 6; i++) begin
         sfr(1'b1, CSM_ADDR_PIN_MONITOR, 8'h01);
         tog(pos[i]);
         tog(pos[i]);
         bd(1'b0);
         sfr(1'b1, CSM_ADDR_PIN_MONITOR, 8'((8'h80 >> i) | 8'h01));
         tog(pos[i]);
         bd(1'b1);
         tog(pos[i]);
         bd(1'b1);
         chk(rcount, 8'h02);
         bd(1'b0);
         chk(rcount, 8'h00);
      end
      // retry limits for modes 00, 01, 10 on the comparator
      for (int m = 0; m < 3; m++) begin
         sfr(1'b1, CSM_ADDR_PIN_MONITOR, 8'(8'h04 | m));
         for (int j = 0; j < 6; j++) begin
            tog(10);
            bd(m == 0 || j < 2 * m);
         end
         if (m > 0) chk(rcount, 8'(2 * m));
         bd(1'b0);
         chk(rcount, 8'h00);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
